// ### logic/acdl_pkg.sv
/*
 Shared constants for the serially clocked conversion and DAC load block.
 Assumes a 250 MHz system clock and a host-driven serial link clock.
*/
package acdl_pkg;
    localparam int CLK_NS = 4;
    localparam real T_TEMP_US = 53.1;
    localparam int TEMP_CYC = int'($ceil(T_TEMP_US * 1000.0 / CLK_NS));
    localparam int TCNV_CYC = 64; // Per-sample conversion, plain default
    localparam int TWU_CYC = 256; // External reference wake-up, plain default
    localparam logic [1:0] MODE_PIN = 2'h0;
    localparam logic [1:0] MODE_PIN_ACQ = 2'h1;
    localparam logic [1:0] MODE_SERIAL = 2'h2;
    localparam logic [1:0] MODE_SCLK = 2'h3;
    localparam logic [1:0] MODE_RESET = MODE_SERIAL;
    localparam logic [1:0] SCAN_REPEAT = 2'h2;
    localparam int CMD_CONV_BIT = 7;
    localparam int CMD_TEMP_BIT = 0;
    localparam int BYTE_W = 8;
    localparam logic [2:0] BIT_LAST = 3'h7;
    localparam int WORD_W = 16;
    localparam logic [3:0] LEAD_ZEROS = 4'h0;
    localparam logic [1:0] SUB_BITS = 2'h0;
    localparam int ADC_W = 10;
    localparam int TEMP_W = 12;
    localparam logic [4:0] TEMP_ZERO_BYTES = 5'h18;
    localparam logic [4:0] TEMP_OUT_BYTES = 5'h02;
    localparam logic [1:0] NOP_PD_COUNT = 2'h2;
    localparam logic [1:0] SER_CONV_BYTES = 2'h2;
    localparam int DAC_N = 4;
    localparam int DAC_W = 10;
    localparam int SYNC_N = 5;
    localparam int SY_CS = 0;
    localparam int SY_CNV = 1;
    localparam int SY_LOAD = 2;
    localparam int SY_RX = 3;
    localparam int SY_ACK = 4;
    localparam logic [SYNC_N-1:0] SYNC_IDLE = 5'h07; // Idle levels, so no false edge after reset
    typedef enum {ST_IDLE, ST_ACQ, ST_SCAN, ST_SER} acdl_state_t;
endpackage

// ### logic/acdl_link_if.sv
/*
 Signals between the link-clock logic and the system-clock core.
 Assumes words are held stable while their toggle crosses.
*/
`timescale 1ns/1ps
interface acdl_link_if;
    logic rst_n;
    logic mode_sclk;
    logic [acdl_pkg::BYTE_W-1:0] rx_byte;
    logic rx_tgl;
    logic [acdl_pkg::WORD_W-1:0] conv_word;
    logic [acdl_pkg::WORD_W-1:0] temp_word;
    logic tx_tgl;
    logic tx_ack;
    modport link (input rst_n, mode_sclk, conv_word, temp_word, tx_tgl, output rx_byte, rx_tgl, tx_ack);
    modport core (output rst_n, mode_sclk, conv_word, temp_word, tx_tgl, input rx_byte, rx_tgl, tx_ack);
endinterface

// ### logic/acdl_serial_link.sv
/*
 Link-clock side: byte capture per frame and result shifter.
 Assumes the host drives the link clock only while chip select is low.
*/
`timescale 1ns/1ps
module acdl_serial_link (
    input wire logic i_sclk,
    input wire logic i_cs_n,
    input wire logic i_din,
    output logic o_dout,
    acdl_link_if.link lnk
);
    logic frame_clr;
    logic [2:0] bit_q;
    logic [6:0] rx_q;
    logic [acdl_pkg::BYTE_W-1:0] byte_now;
    logic [acdl_pkg::BYTE_W-1:0] rx_byte_q;
    logic rx_tgl_q;
    logic mode_s1_q;
    logic mode_s2_q;
    logic tgl_s1_q;
    logic tgl_s2_q;
    logic tgl_s3_q;
    logic [acdl_pkg::WORD_W-1:0] conv_stg_q;
    logic [acdl_pkg::WORD_W-1:0] temp_stg_q;
    logic [acdl_pkg::WORD_W-1:0] sh_q;
    logic [4:0] zleft_q;
    logic byte_end;
    logic is_cmd;
    logic is_zero;
    logic new_words;
    logic conv_load;
    logic temp_load;

    // Byte decode on the closing edge of each byte
    assign frame_clr = i_cs_n | ~lnk.rst_n;
    assign byte_now = {rx_q, i_din};
    assign byte_end = (bit_q == acdl_pkg::BIT_LAST);
    assign is_cmd = byte_end & byte_now[acdl_pkg::CMD_CONV_BIT];
    assign is_zero = byte_end & (byte_now == '0);
    assign new_words = tgl_s2_q ^ tgl_s3_q;
    assign conv_load = is_cmd & mode_s2_q;
    assign temp_load = is_zero & mode_s2_q & (zleft_q == acdl_pkg::TEMP_OUT_BYTES + 5'h01);
    assign o_dout = sh_q[acdl_pkg::WORD_W-1];
    assign lnk.rx_byte = rx_byte_q;
    assign lnk.rx_tgl = rx_tgl_q;
    assign lnk.tx_ack = tgl_s3_q;

    // Chip select high wipes a partial byte, so short writes vanish
    always_ff @(posedge i_sclk or posedge frame_clr) begin
        if (frame_clr) begin
            bit_q <= '0;
            rx_q <= '0;
        end else begin
            bit_q <= bit_q + 3'h1;
            rx_q <= byte_now[6:0];
        end
    end

    // Crossings in from the core and completed-byte hand-off
    always_ff @(posedge i_sclk or negedge lnk.rst_n) begin
        if (!lnk.rst_n) begin
            mode_s1_q <= 1'b0;
            mode_s2_q <= 1'b0;
            tgl_s1_q <= 1'b0;
            tgl_s2_q <= 1'b0;
            tgl_s3_q <= 1'b0;
            conv_stg_q <= '0;
            temp_stg_q <= '0;
            rx_byte_q <= '0;
            rx_tgl_q <= 1'b0;
        end else begin
            mode_s1_q <= lnk.mode_sclk;
            mode_s2_q <= mode_s1_q;
            tgl_s1_q <= lnk.tx_tgl;
            tgl_s2_q <= tgl_s1_q;
            tgl_s3_q <= tgl_s2_q;
            if (new_words) begin
                conv_stg_q <= lnk.conv_word;
                temp_stg_q <= lnk.temp_word;
            end
            if (byte_end) begin
                rx_byte_q <= byte_now;
                rx_tgl_q <= ~rx_tgl_q;
            end
        end
    end

    // Shifter moves on rising edges only; it survives gaps in chip select
    always_ff @(posedge i_sclk or negedge lnk.rst_n) begin
        if (!lnk.rst_n) begin
            sh_q <= '0;
            zleft_q <= '0;
        end else begin
            if (temp_load) begin
                sh_q <= temp_stg_q;
            end else if (conv_load) begin
                sh_q <= conv_stg_q;
            end else begin
                sh_q <= {sh_q[acdl_pkg::WORD_W-2:0], 1'b0};
            end
            if (conv_load) begin
                zleft_q <= byte_now[acdl_pkg::CMD_TEMP_BIT] ? acdl_pkg::TEMP_ZERO_BYTES : 5'h00;
            end else if (is_zero && zleft_q != 5'h00) begin
                zleft_q <= zleft_q - 5'h01;
            end else if (byte_end) begin
                zleft_q <= 5'h00;
            end
        end
    end

    // Result frame opens with its four zero bits
    sequence s_lead_zeros;
        !o_dout [*4];
    endsequence
    property p_conv_frame;
        @(posedge i_sclk) disable iff (!lnk.rst_n) (conv_load && !temp_load) |=> s_lead_zeros;
    endproperty
    a_conv_frame: assert property (p_conv_frame) else $error("result frame lacks leading zeros");
    property p_temp_out;
        @(posedge i_sclk) disable iff (!lnk.rst_n) temp_load |=> (sh_q == $past(temp_stg_q));
    endproperty
    a_temp_out: assert property (p_temp_out) else $error("temperature word not shifted out");
endmodule // acdl_serial_link

// ### logic/acdl_conv_ctrl.sv
/*
 Conversion sequencing, power control and DAC register load.
 Assumes the link clock is driven by the host and config ports are
 static while they are being used.
*/
// What this block does
// - Clock mode 11 converts one at a time, started by a command byte.
// - Mode 11 skips scan, averaging and buffering; result shifts out during conversion.
// - Mode 11 changes the serial result output on rising link clock edges.
// - Two zero bytes after a command power down the analog cells.
// - Bias keep-alive high keeps the bias block powered regardless.
// - Temperature result shifts out in twelve-bit form in the last two bytes.
// - Modes 00 and 10 scan time is tcnv times samples times repeats plus extras.
// - A temperature reading adds 53.1 us, otherwise nothing.
// - Repeat count is one unless scan mode is 10.
// - Mode 01 timing follows the convert-start pin, without reference turn-on.
// - Mode 11 timing follows the link clock and chip select gaps.
// - Low load strobe copies every DAC input register to its DAC register.
// - Load strobe held low makes the DAC registers transparent.
// - Software DAC update takes effect at the chip select rise after the command.
// - Reset sets clock mode 10, where a command byte alone starts a scan.
// - Conversion results go out as two bytes, MSB first, four zeros, data, two sub-bits.
// - A byte cut short by chip select is discarded.
`timescale 1ns/1ps
module acdl_conv_ctrl #(
    parameter int P_TEMP_CYC = acdl_pkg::TEMP_CYC,
    parameter int P_TCNV_CYC = acdl_pkg::TCNV_CYC,
    parameter int P_TWU_CYC = acdl_pkg::TWU_CYC
) (
    input wire logic I_CLK_SYS,
    input wire logic I_RSTN,
    input wire logic I_SCLK,
    input wire logic I_CS_N,
    input wire logic I_DIN,
    input wire logic I_CONVERT_START_PIN_N,
    input wire logic I_DAC_LOAD_STROBE_N,
    input wire logic I_SETUP_WR,
    input wire logic I_CLOCK_MODE_SELECT_HI,
    input wire logic I_CLOCK_MODE_SELECT_LO,
    input wire logic I_SCAN_MODE_HI,
    input wire logic I_SCAN_MODE_LO,
    input wire logic I_BIAS_KEEP_ALIVE,
    input wire logic I_EXT_REF_USED,
    input wire logic [5:0] I_AVG_SAMPLES,
    input wire logic [4:0] I_SCAN_REPEAT,
    input wire logic [acdl_pkg::ADC_W-1:0] I_ADC_RESULT,
    input wire logic [acdl_pkg::TEMP_W-1:0] I_TEMP_RESULT,
    input wire logic I_DAC_WR,
    input wire logic [1:0] I_DAC_SEL,
    input wire logic [acdl_pkg::DAC_W-1:0] I_DAC_DATA,
    input wire logic I_DAC_SW_LOAD,
    output logic O_DOUT,
    output logic O_DOUT_OE,
    output logic [1:0] O_CLOCK_MODE,
    output logic O_ANALOG_PWR_ON,
    output logic O_BIAS_PWR_ON,
    output logic O_CONV_BUSY,
    output logic O_EOC_N,
    output logic [31:0] O_SCAN_TIME,
    output logic [acdl_pkg::DAC_N*acdl_pkg::DAC_W-1:0] O_DAC_REG
);
    acdl_link_if lnk ();

    acdl_serial_link u_link (
        .i_sclk(I_SCLK),
        .i_cs_n(I_CS_N),
        .i_din(I_DIN),
        .o_dout(O_DOUT),
        .lnk(lnk)
    );

    function automatic logic f_mode(input logic [1:0] m, input logic [1:0] want);
        return m == want;
    endfunction

    logic [acdl_pkg::SYNC_N-1:0] sync_in;
    logic [acdl_pkg::SYNC_N-1:0] s1_q;
    logic [acdl_pkg::SYNC_N-1:0] s2_q;
    logic [acdl_pkg::SYNC_N-1:0] s3_q;
    logic link_rst_q;
    logic [1:0] mode_q;
    logic [1:0] scan_q;
    acdl_pkg::acdl_state_t st_q;
    acdl_pkg::acdl_state_t st_d;
    logic [31:0] timer_q;
    logic [31:0] timer_d;
    logic [1:0] ser_q;
    logic [1:0] ser_d;
    logic tempreq_q;
    logic [4:0] temp_left_q;
    logic [1:0] nop_q;
    logic pd_q;
    logic pwr_q;
    logic bias_q;
    logic eoc_n_q;
    logic [31:0] total_q;
    logic tx_tgl_q;
    logic [acdl_pkg::WORD_W-1:0] conv_word_q;
    logic [acdl_pkg::WORD_W-1:0] temp_word_q;
    logic [acdl_pkg::DAC_W-1:0] dac_in_q [acdl_pkg::DAC_N];
    logic [acdl_pkg::DAC_W-1:0] dac_q [acdl_pkg::DAC_N];
    logic [acdl_pkg::DAC_N*acdl_pkg::DAC_W-1:0] dac_in_flat;
    logic sw_pend_q;

    // Event decode from synchronised pins and link toggles
    wire cs_rise = s2_q[acdl_pkg::SY_CS] & ~s3_q[acdl_pkg::SY_CS];
    wire cs_fall = ~s2_q[acdl_pkg::SY_CS] & s3_q[acdl_pkg::SY_CS];
    wire cnv_fall = ~s2_q[acdl_pkg::SY_CNV] & s3_q[acdl_pkg::SY_CNV];
    wire cnv_rise = s2_q[acdl_pkg::SY_CNV] & ~s3_q[acdl_pkg::SY_CNV];
    wire load_lo = ~s2_q[acdl_pkg::SY_LOAD];
    wire rx_ev = s2_q[acdl_pkg::SY_RX] ^ s3_q[acdl_pkg::SY_RX];
    wire ack_ok = (s2_q[acdl_pkg::SY_ACK] == tx_tgl_q);
    wire cmd_ev = rx_ev & lnk.rx_byte[acdl_pkg::CMD_CONV_BIT];
    wire nop_ev = rx_ev & (lnk.rx_byte == '0);
    wire cmd_temp = lnk.rx_byte[acdl_pkg::CMD_TEMP_BIT];
    wire in_sclk = f_mode(mode_q, acdl_pkg::MODE_SCLK);
    wire in_serial = f_mode(mode_q, acdl_pkg::MODE_SERIAL);
    wire in_pin = f_mode(mode_q, acdl_pkg::MODE_PIN);
    wire in_acq = f_mode(mode_q, acdl_pkg::MODE_PIN_ACQ);
    wire pd_hit = in_sclk & nop_ev & (temp_left_q == 5'h00) & (nop_q + 2'h1 == acdl_pkg::NOP_PD_COUNT);

    // Scan time terms; repeats collapse to one outside scan mode 10
    wire [31:0] nscan = (scan_q == acdl_pkg::SCAN_REPEAT) ? 32'(I_SCAN_REPEAT) : 32'h1;
    wire [31:0] t_samp = 32'(P_TCNV_CYC) * 32'(I_AVG_SAMPLES) * nscan;
    wire [31:0] t_temp = (cmd_ev ? cmd_temp : tempreq_q) ? 32'(P_TEMP_CYC) : 32'h0;
    wire [31:0] t_wu = I_EXT_REF_USED ? 32'(P_TWU_CYC) : 32'h0;
    wire [31:0] scan_total = t_samp + t_temp + t_wu;

    assign sync_in = {lnk.tx_ack, lnk.rx_tgl, I_DAC_LOAD_STROBE_N, I_CONVERT_START_PIN_N, I_CS_N};
    assign lnk.rst_n = link_rst_q;
    assign lnk.mode_sclk = in_sclk;
    assign lnk.conv_word = conv_word_q;
    assign lnk.temp_word = temp_word_q;
    assign lnk.tx_tgl = tx_tgl_q;
    assign O_DOUT_OE = ~I_CS_N;
    assign O_CLOCK_MODE = mode_q;
    assign O_ANALOG_PWR_ON = pwr_q;
    assign O_BIAS_PWR_ON = bias_q;
    assign O_CONV_BUSY = (st_q != acdl_pkg::ST_IDLE);
    assign O_EOC_N = eoc_n_q;
    assign O_SCAN_TIME = total_q;

    // Two-stage synchronisers; third stage only for edge detection
    always_ff @(posedge I_CLK_SYS) begin
        if (!I_RSTN) begin
            s1_q <= acdl_pkg::SYNC_IDLE;
            s2_q <= acdl_pkg::SYNC_IDLE;
            s3_q <= acdl_pkg::SYNC_IDLE;
            link_rst_q <= 1'b0;
        end else begin
            s1_q <= sync_in;
            s2_q <= s1_q;
            s3_q <= s2_q;
            link_rst_q <= 1'b1;
        end
    end

    // Mode and scan configuration, latched on setup writes
    always_ff @(posedge I_CLK_SYS) begin
        if (!I_RSTN) begin
            mode_q <= acdl_pkg::MODE_RESET;
            scan_q <= '0;
        end else if (I_SETUP_WR) begin
            mode_q <= {I_CLOCK_MODE_SELECT_HI, I_CLOCK_MODE_SELECT_LO};
            scan_q <= {I_SCAN_MODE_HI, I_SCAN_MODE_LO};
        end
    end

    // Sequencer next state; one conversion owner at a time
    always_comb begin
        st_d = st_q;
        timer_d = timer_q;
        ser_d = ser_q;
        case (st_q)
            acdl_pkg::ST_IDLE: begin
                if (in_sclk && cmd_ev) begin
                    st_d = acdl_pkg::ST_SER;
                    ser_d = '0;
                end else if ((in_serial && cmd_ev) || (in_pin && cnv_fall)) begin
                    st_d = acdl_pkg::ST_SCAN;
                    timer_d = scan_total;
                end else if (in_acq && cnv_fall) begin
                    st_d = acdl_pkg::ST_ACQ;
                end
            end
            acdl_pkg::ST_ACQ: begin
                if (cnv_rise) begin
                    st_d = acdl_pkg::ST_SCAN;
                    timer_d = 32'(P_TCNV_CYC);
                end
            end
            acdl_pkg::ST_SCAN: begin
                timer_d = timer_q - 32'h1;
                if (timer_q <= 32'h1) begin
                    st_d = acdl_pkg::ST_IDLE;
                end
            end
            acdl_pkg::ST_SER: begin
                // Ends after two link bytes, however long the gaps; a command as second byte starts the next one
                if (rx_ev) begin
                    ser_d = ser_q + 2'h1;
                    if (ser_q + 2'h1 == acdl_pkg::SER_CONV_BYTES) begin
                        st_d = cmd_ev ? acdl_pkg::ST_SER : acdl_pkg::ST_IDLE;
                        ser_d = '0;
                    end
                end
            end
            default: st_d = acdl_pkg::ST_IDLE;
        endcase
    end

    wire conv_done = (st_q != acdl_pkg::ST_IDLE) && (st_d == acdl_pkg::ST_IDLE);

    // Sequencer registers and end-of-conversion flag
    always_ff @(posedge I_CLK_SYS) begin
        if (!I_RSTN) begin
            st_q <= acdl_pkg::ST_IDLE;
            timer_q <= '0;
            ser_q <= '0;
            eoc_n_q <= 1'b1;
            total_q <= '0;
        end else begin
            st_q <= st_d;
            timer_q <= timer_d;
            ser_q <= ser_d;
            total_q <= scan_total;
            if (conv_done) begin
                eoc_n_q <= 1'b0; // Completion beats a same-cycle clear
            end else if (cs_fall || cnv_fall) begin
                eoc_n_q <= 1'b1;
            end
        end
    end

    // Idle-byte power down; zero bytes of a temperature run do not count
    always_ff @(posedge I_CLK_SYS) begin
        if (!I_RSTN) begin
            tempreq_q <= 1'b0;
            temp_left_q <= '0;
            nop_q <= '0;
            pd_q <= 1'b1;
        end else begin
            if (cmd_ev) begin
                tempreq_q <= cmd_temp;
                temp_left_q <= (in_sclk && cmd_temp) ? acdl_pkg::TEMP_ZERO_BYTES : 5'h00;
                nop_q <= '0;
                pd_q <= 1'b0;
            end else if (nop_ev && temp_left_q != 5'h00) begin
                temp_left_q <= temp_left_q - 5'h01;
            end else if (pd_hit) begin
                pd_q <= 1'b1;
            end else if (nop_ev && nop_q != acdl_pkg::NOP_PD_COUNT) begin
                nop_q <= nop_q + 2'h1;
            end
        end
    end

    // Power outputs; other modes power up only while converting, bias also while keep-alive is high
    always_ff @(posedge I_CLK_SYS) begin
        if (!I_RSTN) begin
            pwr_q <= 1'b0;
            bias_q <= 1'b0;
        end else begin
            pwr_q <= in_sclk ? ~pd_q : (st_q != acdl_pkg::ST_IDLE);
            bias_q <= (in_sclk ? ~pd_q : (st_q != acdl_pkg::ST_IDLE)) | I_BIAS_KEEP_ALIVE;
        end
    end

    // Result words cross by toggle; held until the link acknowledges
    always_ff @(posedge I_CLK_SYS) begin
        if (!I_RSTN) begin
            tx_tgl_q <= 1'b0;
            conv_word_q <= '0;
            temp_word_q <= '0;
        end else if (ack_ok) begin
            conv_word_q <= {acdl_pkg::LEAD_ZEROS, I_ADC_RESULT, acdl_pkg::SUB_BITS};
            temp_word_q <= {acdl_pkg::LEAD_ZEROS, I_TEMP_RESULT};
            tx_tgl_q <= ~tx_tgl_q;
        end
    end

    // Software load waits for the closing chip select edge
    always_ff @(posedge I_CLK_SYS) begin
        if (!I_RSTN) begin
            sw_pend_q <= 1'b0;
        end else if (I_DAC_SW_LOAD) begin
            sw_pend_q <= 1'b1;
        end else if (cs_rise) begin
            sw_pend_q <= 1'b0;
        end
    end

    wire dac_copy = load_lo | (sw_pend_q & cs_rise);

    // DAC input and output registers per channel
    for (genvar i = 0; i < acdl_pkg::DAC_N; i++) begin : g_dac
        always_ff @(posedge I_CLK_SYS) begin
            if (!I_RSTN) begin
                dac_in_q[i] <= '0;
                dac_q[i] <= '0;
            end else begin
                if (I_DAC_WR && I_DAC_SEL == 2'(i)) begin
                    dac_in_q[i] <= I_DAC_DATA;
                end
                if (dac_copy) begin
                    dac_q[i] <= dac_in_q[i];
                end
            end
        end
        assign O_DAC_REG[i*acdl_pkg::DAC_W +: acdl_pkg::DAC_W] = dac_q[i];
        assign dac_in_flat[i*acdl_pkg::DAC_W +: acdl_pkg::DAC_W] = dac_in_q[i];
    end

    default clocking cb @(posedge I_CLK_SYS); endclocking
    default disable iff (!I_RSTN);

    property p_mode_hold;
        $changed(mode_q) |-> $past(I_SETUP_WR);
    endproperty
    a_mode_hold: assert property (p_mode_hold) else $error("clock mode changed without setup");
    sequence s_ser_start;
        in_sclk && cmd_ev && st_q == acdl_pkg::ST_IDLE;
    endsequence
    property p_ser_single;
        s_ser_start |=> (st_q == acdl_pkg::ST_SER && ser_q == 2'h0);
    endproperty
    a_ser_single: assert property (p_ser_single) else $error("serial conversion not started");
    property p_no_scan;
        (in_sclk && st_q == acdl_pkg::ST_IDLE && !I_SETUP_WR) |=> st_q != acdl_pkg::ST_SCAN;
    endproperty
    a_no_scan: assert property (p_no_scan) else $error("scan ran in serial clock mode");
    property p_pd_nops;
        pd_hit && !I_BIAS_KEEP_ALIVE |=> ##1 (!O_ANALOG_PWR_ON && !O_BIAS_PWR_ON);
    endproperty
    a_pd_nops: assert property (p_pd_nops) else $error("no power down after idle bytes");
    property p_bias;
        (I_BIAS_KEEP_ALIVE && I_RSTN) |=> O_BIAS_PWR_ON; // Sampled reset skips the release edge
    endproperty
    a_bias: assert property (p_bias) else $error("bias dropped with keep-alive set");
    property p_scan_len;
        (st_q == acdl_pkg::ST_IDLE && in_serial && cmd_ev) |=> (timer_q == $past(scan_total));
    endproperty
    a_scan_len: assert property (p_scan_len) else $error("scan timer not loaded with total");
    property p_load_follow;
        load_lo |=> (O_DAC_REG == $past(dac_in_flat));
    endproperty
    a_load_follow: assert property (p_load_follow) else $error("DAC registers did not follow inputs");
    property p_dac_hold;
        $changed(O_DAC_REG) |-> $past(dac_copy);
    endproperty
    a_dac_hold: assert property (p_dac_hold) else $error("DAC register changed without load");
endmodule // acdl_conv_ctrl

// ### tb/acdl_host_model.sv
/*
 Host serial controller model: frames bytes with chip select and link clock.
 Assumes the caller spaces frames; the link clock runs only inside frames.
*/
`timescale 1ns/1ps
module acdl_host_model (
    input wire logic i_dout,
    output logic o_sclk,
    output logic o_cs_n,
    output logic o_din
);
    // Clock idles low, select idles high
    initial begin
        o_sclk = 1'b0;
        o_cs_n = 1'b1;
        o_din = 1'b1;
    end
    // One byte MSB first, 80 ns link period, result sampled at each falling edge
    task automatic xfer(input logic [7:0] tx, input int nb, output logic [7:0] rx);
        rx = 8'h00;
        #7 o_cs_n = 1'b0;
        #40;
        for (int i = 0; i < nb; i++) begin
            o_din = tx[7-i];
            #40 o_sclk = 1'b1;
            #40 o_sclk = 1'b0;
            rx = {rx[6:0], i_dout};
        end
        #40 o_cs_n = 1'b1;
        o_din = ~o_din; // Released line shows the inverse, not the last bit
        #40;
    endtask
endmodule // acdl_host_model

// ### tb/acdl_test.sv
/*
 Self-checking bench for the conversion sequencer and DAC load.
 Assumes the host model frames every byte and the system clock is 250 MHz.
*/
`timescale 1ns/1ps
`define CHK(n, e, s) begin compares++; if ((s) !== (e)) begin fails++; $display("mismatch %s exp %0h got %0h", n, e, s); end end
module adc_sclk_timed_conversion_and_dac_load_test;
    logic clk = 1'b0, rstn = 1'b0, setup_wr = 1'b0, ck_hi = 1'b0, ck_lo = 1'b0, sc_hi = 1'b0, sc_lo = 1'b0;
    logic keep = 1'b1, ext = 1'b1, dac_wr = 1'b0, sw_ld = 1'b0, ld_n = 1'b1, cnv_n = 1'b1;
    logic [5:0] avg = 6'h03;
    logic [4:0] rep = 5'h05;
    logic [1:0] sel = 2'h0;
    logic [9:0] dac_d = 10'h000;
    logic sclk, cs_n, din, dout, oe, apwr, bpwr, busy, eoc_n;
    logic [1:0] mode;
    logic [31:0] stime;
    logic [39:0] dreg;
    logic [7:0] r0, r1, r2;
    int fails = 0, compares = 0, cyc = 0;
    acdl_conv_ctrl #(.P_TEMP_CYC(20)) dut (.I_CLK_SYS(clk), .I_RSTN(rstn), .I_SCLK(sclk), .I_CS_N(cs_n),
        .I_DIN(din), .I_CONVERT_START_PIN_N(cnv_n), .I_DAC_LOAD_STROBE_N(ld_n), .I_SETUP_WR(setup_wr),
        .I_CLOCK_MODE_SELECT_HI(ck_hi), .I_CLOCK_MODE_SELECT_LO(ck_lo), .I_SCAN_MODE_HI(sc_hi),
        .I_SCAN_MODE_LO(sc_lo), .I_BIAS_KEEP_ALIVE(keep), .I_EXT_REF_USED(ext), .I_AVG_SAMPLES(avg),
        .I_SCAN_REPEAT(rep), .I_ADC_RESULT(10'h2A5), .I_TEMP_RESULT(12'hA5C), .I_DAC_WR(dac_wr),
        .I_DAC_SEL(sel), .I_DAC_DATA(dac_d), .I_DAC_SW_LOAD(sw_ld), .O_DOUT(dout), .O_DOUT_OE(oe),
        .O_CLOCK_MODE(mode), .O_ANALOG_PWR_ON(apwr), .O_BIAS_PWR_ON(bpwr), .O_CONV_BUSY(busy),
        .O_EOC_N(eoc_n), .O_SCAN_TIME(stime), .O_DAC_REG(dreg));
    acdl_host_model host (.i_dout(dout), .o_sclk(sclk), .o_cs_n(cs_n), .o_din(din));
    // System clock, 4 ns
    initial forever #2 clk = ~clk;
    task automatic tick(int n);
        repeat (n) @(posedge clk);
    endtask
    task automatic setup(logic [3:0] v);
        @(posedge clk);
        {ck_hi, ck_lo, sc_hi, sc_lo} <= v;
        setup_wr <= 1'b1;
        @(posedge clk);
        setup_wr <= 1'b0;
    endtask
    task automatic dwr(logic [1:0] s, logic [9:0] d);
        @(posedge clk);
        sel <= s;
        dac_d <= d;
        dac_wr <= 1'b1;
        @(posedge clk);
        dac_wr <= 1'b0;
        tick(6);
    endtask
    task automatic end_of_test;
        $display("counts compares %0d fails %0d", compares, fails);
        if (fails == 0 && compares > 0) $display("SIMULATION PASSED");
        else $display("SIMULATION FAILED");
        $finish;
    endtask
    // Cut a hang short
    always @(posedge clk) begin
        cyc++;
        if (cyc == 30000) begin
            fails++;
            end_of_test();
        end
    end
    task automatic t_dac;
        dwr(2'h2, 10'h155);
        `CHK("dac2 held", 10'h000, dreg[29:20]);
        @(posedge clk) ld_n <= 1'b0;
        tick(6);
        `CHK("dac2 load", 10'h155, dreg[29:20]);
        dwr(2'h1, 10'h0AA);
        `CHK("dac1 transparent", 10'h0AA, dreg[19:10]);
        @(posedge clk) ld_n <= 1'b1;
        tick(4);
        dwr(2'h0, 10'h3FF);
        @(posedge clk) sw_ld <= 1'b1;
        @(posedge clk) sw_ld <= 1'b0;
        tick(4);
        `CHK("dac0 pending", 10'h000, dreg[9:0]);
        host.xfer(8'h00, 8, r0);
        tick(8);
        `CHK("dac0 sw load", 10'h3FF, dreg[9:0]);
        $display("test dac done");
    endtask
    task automatic t_scan;
        setup(4'hA);
        host.xfer(8'h81, 8, r0);
        tick(6);
        `CHK("scan time", 32'd1236, stime);
        `CHK("scan busy", 1'b1, busy);
        // Temperature term must be in the timer: still busy 10 cycles before the end
        tick(1193);
        `CHK("scan length", 1'b1, busy);
        repeat (2000) if (eoc_n !== 1'b0) @(posedge clk);
        `CHK("scan eoc", 1'b0, eoc_n);
        setup(4'h8);
        ext <= 1'b0;
        host.xfer(8'h80, 8, r0);
        tick(6);
        `CHK("scan time plain", 32'd192, stime);
        repeat (400) if (eoc_n !== 1'b0) @(posedge clk);
        `CHK("scan plain eoc", 1'b0, eoc_n);
        // Pin low acquires, pin high runs one conversion
        setup(4'h4);
        @(posedge clk) cnv_n <= 1'b0;
        tick(10);
        `CHK("acquire busy", 1'b1, busy);
        @(posedge clk) cnv_n <= 1'b1;
        tick(40);
        `CHK("pin conv busy", 1'b1, busy);
        tick(40);
        `CHK("pin conv eoc", 1'b0, eoc_n);
        // Pin pulse starts a full scan of 192 cycles
        setup(4'h0);
        @(posedge clk) cnv_n <= 1'b0;
        tick(3);
        cnv_n <= 1'b1;
        tick(100);
        `CHK("pin scan busy", 1'b1, busy);
        tick(200);
        `CHK("pin scan eoc", 1'b0, eoc_n);
        $display("test scan done");
    endtask
    task automatic t_sclk;
        setup(4'hC);
        tick(2);
        `CHK("mode", 2'h3, mode);
        host.xfer(8'h80, 8, r0);
        tick(6);
        `CHK("analog on", 1'b1, apwr);
        `CHK("busy", 1'b1, busy);
        host.xfer(8'h00, 8, r0);
        host.xfer(8'h80, 8, r0);
        host.xfer(8'h00, 8, r1);
        host.xfer(8'h00, 8, r2);
        `CHK("frame", {4'h0, 10'h2A5, 2'h0}, {r0[0], r1, r2[7:1]});
        tick(8);
        `CHK("analog off", 1'b0, apwr);
        `CHK("bias kept", 1'b1, bpwr);
        @(posedge clk) keep <= 1'b0;
        host.xfer(8'h00, 8, r0);
        tick(8);
        `CHK("bias off", 1'b0, bpwr);
        host.xfer(8'h80, 4, r0);
        tick(10);
        `CHK("partial busy", 1'b0, busy);
        `CHK("partial power", 1'b0, apwr);
        $display("test serial done");
    endtask
    task automatic t_temp;
        host.xfer(8'h81, 8, r0);
        tick(11250);
        repeat (22) host.xfer(8'h00, 8, r0);
        host.xfer(8'h00, 8, r1);
        host.xfer(8'h00, 8, r2);
        `CHK("temp frame", {4'h0, 12'hA5C}, {r0[0], r1, r2[7:1]});
        $display("test temp done");
    endtask
    // Main sequence
    initial begin
        tick(20);
        rstn <= 1'b1;
        tick(4);
        `CHK("reset mode", 2'h2, mode);
        `CHK("reset dac", 40'h0, dreg);
        `CHK("reset eoc", 1'b1, eoc_n);
        `CHK("oe idle", 1'b0, oe);
        `CHK("reset bias", 1'b1, bpwr);
        $display("test reset done");
        t_dac();
        t_scan();
        t_sclk();
        t_temp();
        end_of_test();
    end
endmodule // adc_sclk_timed_conversion_and_dac_load_test
